/* File: include/mpd_defines.svh */
`ifndef MPD_DEFINES_SVH
`define MPD_DEFINES_SVH
// System clock and derived timebase figures
`define MPD_CLK_HZ 27'd100000000
`define MPD_PHASE_STEPS 27'd1000
`define MPD_PHASE_LAST 10'd999
`define MPD_PHASE_ZERO 10'd0
// Frequency ceiling in Hz, full scale in per-mille, percent to per-mille factor
`define MPD_FREQ_MAX 16'd5000
`define MPD_FULL 20'd1000
`define MPD_PCT_SCALE 20'd10
// Register byte offsets
`define MPD_OFS_FREQ 8'h00
`define MPD_OFS_DUTY 8'h04
`define MPD_OFS_DAMP 8'h08
`define MPD_OFS_DFREQ 8'h0c
`define MPD_OFS_CMD 8'h10
`define MPD_OFS_STAT 8'h14
`define MPD_OFS_GFREQ 8'h18
`define MPD_OFS_EFF 8'h1c
// Command and status register fields
`define MPD_CMD_CH_HI 7
`define MPD_CMD_INIT 8
`define MPD_CMD_CHANGE 9
`define MPD_CMD_PERMILLE 10
`define MPD_STAT_CFG 8
// Reset values
`define MPD_RST_16 16'h0000
`define MPD_RST_32 32'h0000_0000
`define MPD_RST_ACC 27'h000_0000
`endif

/* File: include/mpd_pkg.sv */
package mpd_pkg;
   // Dither half-wave: one-hot, raise or lower the steady duty
   typedef enum logic [1:0] {
      MPD_DITH_UP = 2'b01,
      MPD_DITH_DN = 2'b10
   } mpd_dith_t;
endpackage

/* File: src/mpd_chan.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mpd_defines.svh"
module mpd_chan #(
   parameter int W = 16
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic init_in,
   input wire logic change_in,
   input wire logic permille_in,
   input wire logic [W-1:0] value_in,
   input wire logic [W-1:0] damp_in,
   input wire logic [W-1:0] dfreq_in,
   input wire logic [9:0] phase_in,
   input wire logic period_start_in,
   output logic pwm_out,
   output logic [W-1:0] eff_out,
   output mpd_pkg::mpd_dith_t dith_out
);
   import mpd_pkg::*;

   // Saturate a wide per-mille value to full scale
   function automatic logic [W-1:0] sat_full(input logic [19:0] x);
      sat_full = (x > `MPD_FULL) ? W'(`MPD_FULL) : W'(x);
   endfunction

   logic [W-1:0] duty_ff, damp_ff, dfreq_ff, eff_ff;
   logic [W-1:0] nxt_duty, nxt_eff;
   logic [26:0] dacc_ff, nxt_dacc;
   logic pwm_ff;
   mpd_dith_t dith_ff, nxt_dith;

   // Percent variant reads the low byte only, per-mille the whole word
   wire [19:0] pct_duty = 20'(value_in[7:0]) * `MPD_PCT_SCALE;
   wire [19:0] pm_duty = 20'(value_in);
   wire [19:0] amp_pct = permille_in ? 20'(damp_in) : 20'(damp_in[7:0]);
   wire [W-1:0] norm_duty = sat_full(permille_in ? pm_duty : pct_duty);
   wire [W-1:0] norm_amp = sat_full(amp_pct * `MPD_PCT_SCALE);
   wire load_duty = ce_in && change_in;
   wire [26:0] dinc = 27'({dfreq_ff, 1'b0});
   wire [26:0] dsum = dacc_ff + dinc;
   wire dith_on = (damp_ff != `MPD_RST_16) && (dfreq_ff != `MPD_RST_16);
   wire dith_flip = dith_on && (dsum >= `MPD_CLK_HZ);
   wire [W-1:0] up_eff = sat_full(20'(duty_ff) + 20'(damp_ff));
   wire [W-1:0] dn_eff = (duty_ff > damp_ff) ? duty_ff - damp_ff : `MPD_RST_16;

   assign nxt_duty = load_duty ? norm_duty : duty_ff;
   assign nxt_dacc = !dith_on ? `MPD_RST_ACC : dith_flip ? dsum - `MPD_CLK_HZ : dsum;

   always_comb begin
      nxt_dith = dith_ff;
      nxt_eff = dith_on ? up_eff : duty_ff;
      case (dith_ff)
         MPD_DITH_UP: begin
            if (dith_flip) begin
               nxt_dith = MPD_DITH_DN;
            end
         end
         MPD_DITH_DN: begin
            nxt_eff = dith_on ? dn_eff : duty_ff;
            if (dith_flip) begin
               nxt_dith = MPD_DITH_UP;
            end
         end
         default: begin
            nxt_dith = MPD_DITH_UP;
         end
      endcase
   end

   // Dither settings only move on init; nothing but reset clears them
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         damp_ff <= `MPD_RST_16;
         dfreq_ff <= `MPD_RST_16;
      end else if (ce_in && init_in) begin
         damp_ff <= norm_amp;
         dfreq_ff <= dfreq_in;
      end
   end

   // Effective duty is only swapped at a period start to avoid runt pulses
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         duty_ff <= `MPD_RST_16;
         eff_ff <= `MPD_RST_16;
         dacc_ff <= `MPD_RST_ACC;
         dith_ff <= MPD_DITH_UP;
         pwm_ff <= 1'b0;
      end else if (ce_in) begin
         duty_ff <= nxt_duty;
         dacc_ff <= nxt_dacc;
         dith_ff <= nxt_dith;
         if (period_start_in) begin
            eff_ff <= nxt_eff;
         end
         pwm_ff <= 10'(phase_in) < eff_ff[9:0] || eff_ff >= W'(`MPD_FULL);
      end
   end

   assign pwm_out = pwm_ff;
   assign eff_out = eff_ff;
   assign dith_out = dith_ff;

   a_duty_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !change_in |=> $stable(duty_ff))
      else $error("duty changed without change qualifier");
   a_duty_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && change_in && permille_in && value_in <= W'(`MPD_FULL) |=> duty_ff == $past(value_in))
      else $error("per-mille duty not adopted");
   a_dither_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && init_in |=> dfreq_ff == $past(dfreq_in))
      else $error("dither frequency not captured on init");
   a_eff_clamp: assert property (@(posedge clk_in) disable iff (!resetn_in)
      eff_ff <= W'(`MPD_FULL))
      else $error("effective duty out of range");
   a_zero_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && eff_ff == `MPD_RST_16 |=> !pwm_ff)
      else $error("zero duty drove output");
   a_full_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && eff_ff == W'(`MPD_FULL) |=> pwm_ff)
      else $error("full duty output low");
endmodule
`default_nettype wire

/* File: src/mpd_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mpd_defines.svh"
module mpd_top #(
   parameter int NCH = 4,
   parameter int W = 16
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output logic [NCH-1:0] pwm_out,
   output mpd_pkg::mpd_dith_t dith0_out
);
   import mpd_pkg::*;

   // Register hit on a given offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Clamp the requested group frequency to the ceiling
   function automatic logic [W-1:0] cap_freq(input logic [W-1:0] f);
      cap_freq = (f > `MPD_FREQ_MAX) ? `MPD_FREQ_MAX : f;
   endfunction

   // Staging registers hold one call's parameters until the command write
   logic [W-1:0] freq_ff, duty_ff, damp_ff, dfreq_ff;
   logic [10:0] cmd_ff;
   logic [W-1:0] gfreq_ff, nxt_gfreq;
   logic [NCH-1:0] cfg_ff, nxt_cfg;
   logic [7:0] last_ch_ff;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [26:0] acc_ff, nxt_acc;
   logic [9:0] phase_ff, nxt_phase;
   logic pstart_ff;

   wire [NCH-1:0] pwm_w;
   wire [W-1:0] eff_w [NCH];
   mpd_dith_t dith_w [NCH];

   // Bus decode
   wire wr_freq = wr_in && hit(addr_in, `MPD_OFS_FREQ);
   wire wr_duty = wr_in && hit(addr_in, `MPD_OFS_DUTY);
   wire wr_damp = wr_in && hit(addr_in, `MPD_OFS_DAMP);
   wire wr_dfreq = wr_in && hit(addr_in, `MPD_OFS_DFREQ);
   wire wr_cmd = wr_in && hit(addr_in, `MPD_OFS_CMD);

   // A command write is one call: channel, init, change and variant at once
   wire [7:0] cmd_ch = wdata_in[`MPD_CMD_CH_HI:0];
   wire cmd_init = wr_cmd && wdata_in[`MPD_CMD_INIT];
   wire cmd_change = wr_cmd && wdata_in[`MPD_CMD_CHANGE];
   wire cmd_pm = wdata_in[`MPD_CMD_PERMILLE];
   wire ch_ok = 32'(cmd_ch) < NCH;
   wire grp_init = ce_in && cmd_init && ch_ok;

   // Any init to a channel below NCH sets the shared frequency
   assign nxt_gfreq = grp_init ? cap_freq(freq_ff) : gfreq_ff;

   // Timebase: phase accumulator in thousandths of a PWM period, no divider needed
   wire [26:0] inc = 27'(gfreq_ff) * `MPD_PHASE_STEPS;
   wire [26:0] sum = acc_ff + inc;
   wire step = sum >= `MPD_CLK_HZ;
   wire wrap = step && (phase_ff == `MPD_PHASE_LAST);
   assign nxt_acc = step ? sum - `MPD_CLK_HZ : sum;
   assign nxt_phase = !step ? phase_ff : wrap ? `MPD_PHASE_ZERO : phase_ff + 10'd1;

   // Read mux, answered one cycle after the strobe
   wire [31:0] stat_w = 32'({cfg_ff, 8'h00}) | 32'(pwm_w);
   wire [31:0] eff_sel = (32'(last_ch_ff) < NCH) ? 32'(eff_w[last_ch_ff[1:0]]) : `MPD_RST_32;

   always_comb begin
      nxt_rdata = `MPD_RST_32;
      if (rd_in) begin
         case (addr_in)
            `MPD_OFS_FREQ: nxt_rdata = 32'(freq_ff);
            `MPD_OFS_DUTY: nxt_rdata = 32'(duty_ff);
            `MPD_OFS_DAMP: nxt_rdata = 32'(damp_ff);
            `MPD_OFS_DFREQ: nxt_rdata = 32'(dfreq_ff);
            `MPD_OFS_CMD: nxt_rdata = 32'(cmd_ff);
            `MPD_OFS_STAT: nxt_rdata = stat_w;
            `MPD_OFS_GFREQ: nxt_rdata = 32'(gfreq_ff);
            `MPD_OFS_EFF: nxt_rdata = eff_sel;
            default: nxt_rdata = `MPD_RST_32;
         endcase
      end
   end

   // Configured flags: set by init, cleared only by reset
   always_comb begin
      nxt_cfg = cfg_ff;
      if (grp_init) begin
         nxt_cfg[cmd_ch[1:0]] = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         freq_ff <= `MPD_RST_16;
      end else if (ce_in && wr_freq) begin
         freq_ff <= wdata_in[W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         duty_ff <= `MPD_RST_16;
      end else if (ce_in && wr_duty) begin
         duty_ff <= wdata_in[W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         damp_ff <= `MPD_RST_16;
      end else if (ce_in && wr_damp) begin
         damp_ff <= wdata_in[W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dfreq_ff <= `MPD_RST_16;
      end else if (ce_in && wr_dfreq) begin
         dfreq_ff <= wdata_in[W-1:0];
      end
   end

   a_stage_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && wr_freq |=> freq_ff == $past(wdata_in[W-1:0]))
      else $error("frequency write not staged");
   a_stage_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !(ce_in && wr_in) |=> $stable(freq_ff) && $stable(duty_ff) &&
         $stable(damp_ff) && $stable(dfreq_ff))
      else $error("staging register moved without a write");

   // No soft clear path exists: settings live until reset
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cmd_ff <= '0;
         last_ch_ff <= '0;
      end else if (ce_in && wr_cmd) begin
         cmd_ff <= wdata_in[`MPD_CMD_PERMILLE:0];
         last_ch_ff <= cmd_ch;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gfreq_ff <= `MPD_RST_16;
      end else if (ce_in) begin
         gfreq_ff <= nxt_gfreq;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_ff <= '0;
      end else if (ce_in) begin
         cfg_ff <= nxt_cfg;
      end
   end

   a_cmd_record: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && wr_cmd |=> last_ch_ff == $past(cmd_ch))
      else $error("command channel not recorded");
   a_cfg_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
      grp_init |=> cfg_ff[$past(cmd_ch[1:0])])
      else $error("configured flag not set on init");
   a_cfg_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cfg_ff & $past(cfg_ff)) == $past(cfg_ff))
      else $error("configured flag dropped without reset");
   a_bad_ch: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && wr_cmd && !ch_ok |=> $stable(cfg_ff) && $stable(gfreq_ff))
      else $error("out-of-range channel changed state");

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_ff <= `MPD_RST_ACC;
      end else if (ce_in) begin
         acc_ff <= nxt_acc;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phase_ff <= `MPD_PHASE_ZERO;
      end else if (ce_in) begin
         phase_ff <= nxt_phase;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pstart_ff <= 1'b0;
      end else if (ce_in) begin
         pstart_ff <= wrap;
      end
   end

   a_phase_range: assert property (@(posedge clk_in) disable iff (!resetn_in)
      phase_ff <= `MPD_PHASE_LAST)
      else $error("phase beyond last step");
   a_acc_range: assert property (@(posedge clk_in) disable iff (!resetn_in)
      acc_ff < `MPD_CLK_HZ)
      else $error("phase accumulator overflowed");
   a_time_stop: assert property (@(posedge clk_in) disable iff (!resetn_in)
      gfreq_ff == `MPD_RST_16 |=> $stable(phase_ff))
      else $error("timebase ran without a frequency");
   a_pstart_once: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && pstart_ff |=> !pstart_ff)
      else $error("period start lasted two cycles");
   a_ce_freeze: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !ce_in |=> $stable(acc_ff) && $stable(phase_ff) && $stable(pstart_ff) &&
         $stable(rdata_ff) && $stable(cfg_ff))
      else $error("state moved while clock enable was low");

   // Read data stands for one cycle only; a stalled cycle keeps it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_ff <= `MPD_RST_32;
      end else if (ce_in) begin
         rdata_ff <= nxt_rdata;
      end
   end

   a_read_freq: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && rd_in && addr_in == `MPD_OFS_GFREQ |=> rdata_ff == 32'($past(gfreq_ff)))
      else $error("group frequency read wrong");
   a_read_stat: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && rd_in && addr_in == `MPD_OFS_STAT |=>
         rdata_ff[`MPD_STAT_CFG +: NCH] == $past(cfg_ff))
      else $error("configured flags read wrong");
   a_read_unmapped: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && rd_in && addr_in > `MPD_OFS_EFF |=> rdata_ff == `MPD_RST_32)
      else $error("unmapped read returned data");
   a_cmd_echo: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && rd_in && addr_in == `MPD_OFS_CMD |=> rdata_ff == 32'($past(cmd_ff)))
      else $error("command read-back wrong");

   // One channel per output; the shared phase keeps the group in step
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         wire sel = ch_ok && (32'(cmd_ch) == gi);
         mpd_chan #(
            .W(W)
         ) u_chan (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .ce_in(ce_in),
            .init_in(cmd_init && sel),
            .change_in(cmd_change && sel),
            .permille_in(cmd_pm),
            .value_in(duty_ff),
            .damp_in(damp_ff),
            .dfreq_in(dfreq_ff),
            .phase_in(phase_ff),
            .period_start_in(pstart_ff),
            .pwm_out(pwm_w[gi]),
            .eff_out(eff_w[gi]),
            .dith_out(dith_w[gi])
         );
      end
   endgenerate

   assign rdata_out = rdata_ff;
   assign pwm_out = pwm_w;
   assign dith0_out = dith_w[0];

   a_freq_capture: assert property (@(posedge clk_in) disable iff (!resetn_in)
      grp_init |=> gfreq_ff == cap_freq($past(freq_ff)))
      else $error("group frequency not captured on init");
   a_freq_limit: assert property (@(posedge clk_in) disable iff (!resetn_in)
      gfreq_ff <= `MPD_FREQ_MAX)
      else $error("group frequency above ceiling");
   a_freq_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !grp_init |=> $stable(gfreq_ff))
      else $error("group frequency moved without init");
   a_phase_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && wrap |=> phase_ff == `MPD_PHASE_ZERO && pstart_ff)
      else $error("phase did not wrap to zero");
   a_read_once: assert property (@(posedge clk_in) disable iff (!resetn_in)
      ce_in && !rd_in |=> rdata_ff == `MPD_RST_32)
      else $error("read data stood without a read");
endmodule
`default_nettype wire

/* File: verif/test_multichannel_pwm_dither.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mpd_defines.svh"
module test_multichannel_pwm_dither;
   import mpd_pkg::*;
   logic clk_in;
   logic resetn_in;
   logic ce_in;
   logic [7:0] addr_in;
   logic [31:0] wdata_in;
   logic wr_in;
   logic rd_in;
   logic [31:0] rdata_out;
   logic [3:0] pwm_out;
   mpd_dith_t dith0_out;
   int fail_count;
   int samples_checked;

   mpd_top #(.NCH(4), .W(16)) i_dut (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .rdata_out(rdata_out),
      .pwm_out(pwm_out),
      .dith0_out(dith0_out)
   );

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Every bus task starts and ends just after a rising edge; one idle cycle after a write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      d = rdata_out;
      @(posedge clk_in);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   task automatic cmd(input logic [7:0] ch, input logic ini, input logic chg, input logic pm);
      wr(`MPD_OFS_CMD, {21'h0, pm, chg, ini, ch});
   endtask

   task automatic setup(input logic [7:0] ch, input logic [15:0] f, input logic [15:0] duty,
                        input logic [15:0] damp, input logic [15:0] dfreq, input logic pm);
      wr(`MPD_OFS_FREQ, {16'h0, f});
      wr(`MPD_OFS_DUTY, {16'h0, duty});
      wr(`MPD_OFS_DAMP, {16'h0, damp});
      wr(`MPD_OFS_DFREQ, {16'h0, dfreq});
      cmd(ch, 1'b1, 1'b1, pm);
   endtask

   task automatic t_reset();
      @(negedge clk_in);
      chk({28'h0, pwm_out}, 32'h0);
      chk({30'h0, dith0_out}, {30'h0, MPD_DITH_UP});
      @(posedge clk_in);
      rd_chk(`MPD_OFS_STAT, 32'h0);
      rd_chk(`MPD_OFS_GFREQ, 32'h0);
      rd_chk(8'h20, 32'h0);
   endtask

   // Over-limit request is capped; every channel gets the same frequency
   task automatic t_init();
      setup(8'h00, 16'h1b58, 16'h01f4, 16'h0000, 16'h0000, 1'b1);
      rd_chk(`MPD_OFS_GFREQ, 32'h0000_1388);
      setup(8'h01, 16'h1388, 16'h0096, 16'h0000, 16'h0000, 1'b0);
      setup(8'h03, 16'h1388, 16'h0003, 16'h0005, 16'h09c4, 1'b0);
      rd_chk(`MPD_OFS_GFREQ, 32'h0000_1388);
      // Duty swaps only at a period start: wait one full period of 20000 cycles
      repeat (20100) @(posedge clk_in);
   endtask

   task automatic t_change();
      logic [31:0] d;
      wr(`MPD_OFS_DUTY, 32'h0000_0384);
      cmd(8'h00, 1'b0, 1'b0, 1'b1);
      rd_chk(`MPD_OFS_EFF, 32'h0000_01f4);
      cmd(8'h01, 1'b0, 1'b0, 1'b0);
      rd_chk(`MPD_OFS_EFF, 32'h0000_03e8);
      @(negedge clk_in);
      chk({31'h0, pwm_out[1]}, 32'h1);
      chk({31'h0, pwm_out[2]}, 32'h0);
      @(posedge clk_in);
      cmd(8'h08, 1'b0, 1'b1, 1'b0);
      rd_chk(`MPD_OFS_EFF, 32'h0);
      rd(`MPD_OFS_STAT, d);
      chk({28'h0, d[11:8]}, 32'hb);
   endtask

   // Reads of channel 3 are exactly one period apart, so they fall in opposite dither halves
   task automatic t_dither_duty();
      logic [31:0] v1;
      logic [31:0] v2;
      int cnt;
      cnt = 0;
      cmd(8'h03, 1'b0, 1'b0, 1'b0);
      rd(`MPD_OFS_EFF, v1);
      repeat (19998) begin
         @(negedge clk_in);
         if (pwm_out[0] === 1'b1) begin
            cnt++;
         end
      end
      @(posedge clk_in);
      rd(`MPD_OFS_EFF, v2);
      chk({31'h0, (cnt >= 9950) && (cnt <= 10050)}, 32'h1);
      chk({31'h0, (v1 === 32'h50 && v2 === 32'h0) || (v1 === 32'h0 && v2 === 32'h50)}, 32'h1);
      chk({31'h0, (v1 === 32'h50) || (v2 === 32'h50)}, 32'h1);
      chk({31'h0, (v1 === 32'h0) || (v2 === 32'h0)}, 32'h1);
      chk({31'h0, v1 !== 32'h1e}, 32'h1);
      // A full period has passed since duty 900 was staged without change
      cmd(8'h00, 1'b0, 1'b0, 1'b1);
      rd_chk(`MPD_OFS_EFF, 32'h0000_01f4);
   endtask

   // A frozen clock enable drops strobes and holds every flop
   task automatic t_ce();
      logic [31:0] d;
      ce_in <= 1'b0;
      wr(`MPD_OFS_FREQ, 32'h0000_0064);
      rd(`MPD_OFS_GFREQ, d);
      ce_in <= 1'b1;
      chk(d, 32'h0);
      rd_chk(`MPD_OFS_FREQ, 32'h0000_1388);
   endtask

   task automatic t_rereset();
      rd_chk(`MPD_OFS_GFREQ, 32'h0000_1388);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk({28'h0, pwm_out}, 32'h0);
      @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      rd_chk(`MPD_OFS_GFREQ, 32'h0);
      rd_chk(`MPD_OFS_STAT, 32'h0);
   endtask

   initial begin
      fail_count = 0;
      samples_checked = 0;
      resetn_in = 1'b0;
      ce_in = 1'b1;
      addr_in = 8'h00;
      wdata_in = 32'h0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      t_reset();
      t_init();
      t_change();
      t_dither_duty();
      t_ce();
      t_rereset();
      test_done();
   end

   // Tests need about 40200 cycles; allow a wide margin
   initial begin
      #800000;
      fail_count++;
      test_done();
   end
endmodule
`default_nettype wire
